// ==== rtl/sba_activation.sv ====
// Layer-1 activation state machine for terminal and line-termination modes
//
// Overview of operation
// - Terminal reports clocks-up, quiescent before clock stop
// - Report deactivate request when line deactivates
// - Trunk-terminal mode reports slip on excessive wander
// - Unplugged code replaces clocks-up when disconnected
// - Error code on soft reset, or on reset pin while clock stop is clear
// - Level-unsynced and INFO2-received indications
// - Test codes for loop and continuous pulses
// - Active indication follows selected priority class
// - Awake detector on except reset; clock stop
// - Timing request powers up; indicate after clocks
// - INFO0 flywheel to pending deactivation, exit rules
// - Terminal activation sends INFO1, stays indefinitely
// - Any line signal stops INFO1 promptly
// - INFO2 answered with INFO3, await INFO4
// - INFO4 reaches activated state promptly
// - Second highway mode needs activate before pass-through
// - Lost framing waits for INFO2, INFO4, INFO0
// - Loop active reports test or awake-test code
// - Soft reset idles; leave with deactivate-up
// - Line-termination command codes
// - Line-termination indication codes
// - INFO2 after 4 ms of awake pulses
// - INFO4 on INFO3, INFO2 on lost sync
// - Deactivated after 16 ms INFO0 or 32 ms
//
// Design decisions made here: the register offsets and the address-and-strobe port.
`include "sba_defs.svh"
`default_nettype none
module sba_activation #(
  parameter logic [15:0] CLK_START_CYC = 16'(`SBA_CLK_START_US * `SBA_CLK_MHZ)
) (
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic [3:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic wr_stb_i,
  input wire logic rd_stb_i,
  output logic [31:0] rdata_o,
  input wire logic [3:0] cmd_i,
  output logic [3:0] ind_o,
  input wire logic frame_tick_i,
  input wire logic [2:0] rx_info_i,
  input wire logic slip_i,
  input wire logic reset_pin_i,
  input wire logic upstream_data_line_i,
  input wire logic bus_connected_sense_i,
  output logic [2:0] tx_info_o,
  output logic clocks_on_o,
  output logic awake_en_o,
  output logic pass_through_o,
  output logic loop_o
);
  import sba_pkg::*;

  sba_core_t r, n;
  sba_tmr_if ta ();
  sba_tmr_if tb ();
  logic level;
  logic te;
  logic is_ar;

  function automatic logic [3:0] rx_ind(input logic lvl);
    rx_ind = lvl ? `SBA_LOST_FRAMING_UP_CODE : `SBA_LOST_LEVEL_CODE;
  endfunction : rx_ind

  function automatic logic [3:0] up_ind(input logic on, input logic conn);
    if (!on) begin
      up_ind = `SBA_DEACTIVATE_ACK_DOWN;
    end else begin
      up_ind = conn ? `SBA_CLOCKS_UP_INDICATION : `SBA_UNPLUGGED_CODE;
    end
  endfunction : up_ind

  assign level = rx_info_i != `SBA_INFO0;
  assign te = r.mode != SBA_MODE_LTS;
  assign is_ar = cmd_i == `SBA_ACTIVATE_PRIO_LOW_COMMAND ||
                 cmd_i == `SBA_ACTIVATE_PRIO_HIGH_COMMAND;

  always_comb begin
    n = r;
    n.rp1 = reset_pin_i;
    n.rp2 = r.rp1;
    n.dl1 = upstream_data_line_i;
    n.dl2 = r.dl1;
    n.cs1 = bus_connected_sense_i;
    n.cs2 = r.cs1;
    n.rdata = 32'h00000000;
    if (wr_stb_i) begin
      if (addr_i == `SBA_REG_CTRL) begin
        n.mode = sba_mode_t'(wdata_i[`SBA_CTRL_MODE_LSB +: 2]);
        n.clkstop = wdata_i[`SBA_CTRL_CLKSTOP_BIT];
        n.hw2 = wdata_i[`SBA_CTRL_HW2_BIT];
      end
    end
    if (rd_stb_i) begin
      if (addr_i == `SBA_REG_CTRL) begin
        n.rdata = {28'h0000000, r.hw2, r.clkstop, r.mode};
      end else if (addr_i == `SBA_REG_STATUS) begin
        n.rdata = {17'h00000, r.state, r.ind, r.tx, r.clk_on, r.pass, r.awake_en};
      end
    end

    // Next state
    if (te) begin
      case (r.state)
        F3_DOWN: begin
          if (cmd_i == `SBA_CLOCK_REQUEST_CODE || !r.dl2) begin
            n.state = F3_UP;
          end else if (is_ar) begin
            n.state = F4_PEND_ACT;
          end else if (level && r.awake_en) begin
            n.state = F5_UNSYNC;
          end
        end
        F3_UP, F4_PEND_ACT: begin
          // A static-low data line carries no command, so it holds power up
          if (cmd_i == `SBA_DEACTIVATE_UP_CODE && r.dl2) begin
            n.state = F3_DOWN;
          end else if (level) begin
            n.state = F5_UNSYNC;
          end else if (is_ar) begin
            n.state = F4_PEND_ACT;
          end
        end
        F3_PEND_DEACT: begin
          if (cmd_i == `SBA_DEACTIVATE_UP_CODE) begin
            n.state = F3_DOWN;
          end else if (level) begin
            n.state = F5_UNSYNC;
          end
        end
        F5_UNSYNC, F6_SYNC, F7_ACTIVE, F8_LOST: begin
          if (ta.done) begin
            n.state = F3_PEND_DEACT;
          end else if (rx_info_i == `SBA_INFO4) begin
            n.state = F7_ACTIVE;
          end else if (rx_info_i == `SBA_INFO2) begin
            n.state = F6_SYNC;
          end else if (rx_info_i == `SBA_RX_UNSYNCED && r.state != F5_UNSYNC) begin
            n.state = F8_LOST;
          end
        end
        LOOP_CLOSED, LOOP_ACTIVE, TEST_CONT, TEST_SINGLE: begin
          if (r.state == LOOP_CLOSED && frame_tick_i) begin
            n.state = LOOP_ACTIVE;
          end
          if (cmd_i == `SBA_DEACTIVATE_UP_CODE) begin
            n.state = F3_DOWN;
          end else if (cmd_i == `SBA_CLOCK_REQUEST_CODE) begin
            n.state = F3_UP;
          end else if (is_ar) begin
            n.state = F4_PEND_ACT;
          end
        end
        IDLE_RESET: begin
          if (cmd_i == `SBA_DEACTIVATE_UP_CODE) begin
            n.state = F3_DOWN;
          end
        end
        default: begin
          n.state = F3_DOWN;
        end
      endcase
      // Unconditional commands override any terminal state
      if (cmd_i == `SBA_SOFT_RESET_COMMAND) begin
        n.state = IDLE_RESET;
      end else if (cmd_i == `SBA_CONTINUOUS_PULSE_COMMAND) begin
        n.state = TEST_CONT;
      end else if (cmd_i == `SBA_SINGLE_PULSE_COMMAND) begin
        n.state = TEST_SINGLE;
      end else if (cmd_i == `SBA_LOOP_ACTIVATE_COMMAND && r.state != LOOP_ACTIVE &&
                   r.state != LOOP_CLOSED) begin
        n.state = LOOP_CLOSED;
      end
      if (r.rp2) begin
        n.state = F3_DOWN;
      end
      if (is_ar) begin
        n.prio_hi = cmd_i == `SBA_ACTIVATE_PRIO_HIGH_COMMAND;
      end
    end else begin
      case (r.state)
        G1_DEACT: begin
          if (rx_info_i == `SBA_INFO1 || cmd_i == `SBA_LT_ACTIVATE_DOWN ||
              cmd_i == `SBA_LT_LOOP_ACTIVATE) begin
            n.state = G2_WAIT;
            n.loop_f = cmd_i == `SBA_LT_LOOP_ACTIVATE;
          end
        end
        G2_WAIT: begin
          if (ta.done) begin
            n.state = G2_SYNC;
          end
        end
        G2_SYNC: begin
          if (rx_info_i == `SBA_INFO3) begin
            n.state = G3_ACTIVE;
          end
        end
        G3_ACTIVE: begin
          n.state = G3_ACTIVE;
        end
        G4_PEND_DEACT: begin
          if (ta.done || tb.done) begin
            n.state = G1_DEACT;
          end
        end
        TEST_CONT, TEST_SINGLE: begin
          if (cmd_i == `SBA_LT_DEACT_ACK_DOWN) begin
            n.state = G1_DEACT;
          end
        end
        default: begin
          n.state = G1_DEACT;
        end
      endcase
      if (cmd_i == `SBA_LT_DEACT_REQUEST && r.state != G1_DEACT && r.state != G4_PEND_DEACT) begin
        n.state = G4_PEND_DEACT;
      end else if (cmd_i == `SBA_LT_CONT_PULSE) begin
        n.state = TEST_CONT;
      end else if (cmd_i == `SBA_LT_SINGLE_PULSE) begin
        n.state = TEST_SINGLE;
      end
      if (r.rp2) begin
        n.state = G1_DEACT;
      end
    end

    // Timers restart whenever the state changes
    n.run_a = 1'b0;
    n.lim_a = `SBA_MS_FRAMES(`SBA_FLYWHEEL_MS);
    n.run_b = (n.state == r.state) && r.state == G4_PEND_DEACT;
    case (r.state)
      F5_UNSYNC, F6_SYNC, F7_ACTIVE, F8_LOST, G4_PEND_DEACT: begin
        n.run_a = !level;
      end
      F3_DOWN: begin
        n.run_a = r.mode == SBA_MODE_TE && r.clkstop && r.clk_on;
        n.lim_a = `SBA_STOP_FRAMES;
      end
      G2_WAIT: begin
        n.run_a = level;
        n.lim_a = `SBA_MS_FRAMES(`SBA_AWAKE_MS);
      end
      default: begin
        n.run_a = 1'b0;
      end
    endcase
    n.run_a = n.run_a && (n.state == r.state);

    // Clocks: stopped in power-down only, restarted after oscillator start-up
    if (r.mode == SBA_MODE_TE && r.clkstop && n.state == F3_DOWN &&
        (ta.done || !r.clk_on)) begin
      n.clk_on = 1'b0;
      n.clk_cnt = 16'h0000;
    end else if (!r.clk_on) begin
      if (r.clk_cnt >= CLK_START_CYC - 16'h0001) begin
        n.clk_on = 1'b1;
        n.clk_cnt = 16'h0000;
      end else begin
        n.clk_cnt = r.clk_cnt + 16'h0001;
      end
    end

    n.awake_en = !r.rp2 && n.state != IDLE_RESET;
    n.slip_f = (r.slip_f && !frame_tick_i) ||
               (slip_i && r.mode == SBA_MODE_LTT && n.state == F7_ACTIVE);
    n.ar_seen = n.state == F7_ACTIVE && (r.ar_seen || is_ar);
    n.pass = (n.state == F7_ACTIVE && (!r.hw2 || n.ar_seen)) ||
             (n.state == G3_ACTIVE && rx_info_i == `SBA_INFO3);
    if (te) begin
      n.loop_f = n.state == LOOP_CLOSED || n.state == LOOP_ACTIVE;
    end else if (n.state == G1_DEACT) begin
      n.loop_f = 1'b0;
    end

    // Transmit signal and indication for the next state
    n.tx = `SBA_INFO0;
    n.ind = `SBA_DEACTIVATE_ACK_DOWN;
    case (n.state)
      F3_DOWN: begin
        n.ind = `SBA_DEACTIVATE_ACK_DOWN;
      end
      F3_UP: begin
        n.ind = up_ind(n.clk_on, r.cs2);
      end
      F3_PEND_DEACT: begin
        n.ind = `SBA_DEACTIVATE_REQUEST_CODE;
      end
      F4_PEND_ACT: begin
        n.tx = `SBA_INFO1;
        n.ind = up_ind(n.clk_on, r.cs2);
      end
      F5_UNSYNC, F8_LOST: begin
        n.ind = `SBA_LEVEL_UNSYNCED_CODE;
      end
      F6_SYNC: begin
        n.tx = `SBA_INFO3;
        n.ind = `SBA_ACTIVATE_REQUEST_DOWN;
      end
      F7_ACTIVE: begin
        n.tx = `SBA_INFO3;
        if (n.slip_f) begin
          n.ind = `SBA_SLIP_DETECTED_CODE;
        end else begin
          n.ind = n.prio_hi ? `SBA_ACTIVE_PRIORITY_HIGH : `SBA_ACTIVE_PRIORITY_LOW;
        end
      end
      LOOP_CLOSED: begin
        n.ind = `SBA_LOOPBACK_TEST_CODE;
      end
      LOOP_ACTIVE: begin
        n.ind = level ? `SBA_AWAKE_LOOPBACK_CODE : `SBA_LOOPBACK_TEST_CODE;
      end
      TEST_CONT: begin
        n.tx = `SBA_TX_CONT;
        n.ind = te ? `SBA_LOOPBACK_TEST_CODE : rx_ind(level);
      end
      TEST_SINGLE: begin
        n.tx = `SBA_TX_SINGLE;
        n.ind = te ? `SBA_DEACTIVATE_ACK_DOWN : rx_ind(level);
      end
      IDLE_RESET: begin
        n.ind = `SBA_ERROR_CODE;
      end
      G1_DEACT: begin
        n.ind = rx_info_i == `SBA_INFO1 ? `SBA_ACTIVATE_REQUEST_UP
                                        : `SBA_LT_DEACTIVATED_CODE;
      end
      G2_WAIT: begin
        n.ind = rx_info_i == `SBA_INFO1 ? `SBA_ACTIVATE_REQUEST_UP : rx_ind(level);
      end
      G4_PEND_DEACT: begin
        n.ind = rx_info_i == `SBA_INFO3 ? `SBA_ACTIVATE_INDICATION_UP : rx_ind(level);
      end
      G2_SYNC: begin
        n.tx = `SBA_INFO2;
        n.ind = rx_ind(level);
      end
      G3_ACTIVE: begin
        if (rx_info_i == `SBA_INFO3) begin
          n.tx = `SBA_INFO4;
          n.ind = `SBA_ACTIVATE_INDICATION_UP;
        end else begin
          n.tx = `SBA_INFO2;
          n.ind = rx_ind(level);
        end
      end
      default: begin
        n.tx = `SBA_INFO0;
      end
    endcase
    if (te && r.rp2 && !r.clkstop) begin
      n.ind = `SBA_ERROR_CODE;
    end
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      r <= '0;
      r.state <= F3_DOWN;
      r.ind <= `SBA_DEACTIVATE_ACK_DOWN;
      r.clk_on <= 1'b1;
      r.awake_en <= 1'b1;
      r.lim_a <= `SBA_MS_FRAMES(`SBA_FLYWHEEL_MS);
      r.rp1 <= 1'b0;
      r.dl1 <= 1'b1;
      r.dl2 <= 1'b1;
      r.cs1 <= 1'b1;
      r.cs2 <= 1'b1;
    end else begin
      r <= n;
    end
  end

  // Frame timers: flywheel/awake/stop timer and the deactivation guard
  assign ta.tick = frame_tick_i;
  assign ta.run = r.run_a;
  assign ta.limit = r.lim_a;
  assign tb.tick = frame_tick_i;
  assign tb.run = r.run_b;
  assign tb.limit = `SBA_MS_FRAMES(`SBA_GUARD_MS);

  sba_frame_timer u_tmr_a (
    .clk_i(clk_i),
    .sys_rst_i(sys_rst_i),
    .t(ta.tmr)
  );
  sba_frame_timer u_tmr_b (
    .clk_i(clk_i),
    .sys_rst_i(sys_rst_i),
    .t(tb.tmr)
  );

  assign rdata_o = r.rdata;
  assign ind_o = r.ind;
  assign tx_info_o = r.tx;
  assign clocks_on_o = r.clk_on;
  assign awake_en_o = r.awake_en;
  assign pass_through_o = r.pass;
  assign loop_o = r.loop_f;
endmodule : sba_activation
`default_nettype wire

// ==== rtl/sba_defs.svh ====
// Constants for the S-bus layer-1 activation block
`ifndef SBA_DEFS_SVH
`define SBA_DEFS_SVH
// Terminal-mode indications
`define SBA_CLOCKS_UP_INDICATION 4'h7
`define SBA_DEACTIVATE_REQUEST_CODE 4'h0
`define SBA_SLIP_DETECTED_CODE 4'h2
`define SBA_UNPLUGGED_CODE 4'h3
`define SBA_ERROR_CODE 4'h6
`define SBA_LEVEL_UNSYNCED_CODE 4'h4
`define SBA_ACTIVATE_REQUEST_DOWN 4'h8
`define SBA_LOOPBACK_TEST_CODE 4'hA
`define SBA_AWAKE_LOOPBACK_CODE 4'hB
`define SBA_ACTIVE_PRIORITY_LOW 4'hC
`define SBA_ACTIVE_PRIORITY_HIGH 4'hD
`define SBA_DEACTIVATE_ACK_DOWN 4'hF
// Terminal-mode commands
`define SBA_CLOCK_REQUEST_CODE 4'h0
`define SBA_SOFT_RESET_COMMAND 4'h1
`define SBA_CONTINUOUS_PULSE_COMMAND 4'h4
`define SBA_SINGLE_PULSE_COMMAND 4'h2
`define SBA_ACTIVATE_PRIO_LOW_COMMAND 4'h8
`define SBA_ACTIVATE_PRIO_HIGH_COMMAND 4'h9
`define SBA_LOOP_ACTIVATE_COMMAND 4'hA
`define SBA_DEACTIVATE_UP_CODE 4'hF
// Line-termination commands
`define SBA_LT_DEACT_REQUEST 4'h0
`define SBA_LT_CONT_PULSE 4'h1
`define SBA_LT_SINGLE_PULSE 4'h2
`define SBA_LT_ACTIVATE_DOWN 4'h8
`define SBA_LT_LOOP_ACTIVATE 4'hA
`define SBA_LT_DEACT_ACK_DOWN 4'hF
// Line-termination indications
`define SBA_LOST_LEVEL_CODE 4'h1
`define SBA_LOST_FRAMING_UP_CODE 4'h4
`define SBA_ACTIVATE_REQUEST_UP 4'h8
`define SBA_ACTIVATE_INDICATION_UP 4'hC
`define SBA_LT_DEACTIVATED_CODE 4'hF
// Line signal codes
`define SBA_INFO0 3'h0
`define SBA_INFO1 3'h1
`define SBA_INFO2 3'h2
`define SBA_INFO3 3'h3
`define SBA_INFO4 3'h4
`define SBA_TX_CONT 3'h5
`define SBA_TX_SINGLE 3'h6
`define SBA_RX_UNSYNCED 3'h7
// Timing
`define SBA_CLK_MHZ 10
`define SBA_FRAME_US 250
`define SBA_FLYWHEEL_MS 16
`define SBA_GUARD_MS 32
`define SBA_AWAKE_MS 4
`define SBA_CLK_START_US 500
`define SBA_STOP_FRAMES 8'h04
`define SBA_MS_FRAMES(ms) 8'((ms) * 1000 / `SBA_FRAME_US)
// Register port
`define SBA_REG_CTRL 4'h0
`define SBA_REG_STATUS 4'h4
`define SBA_CTRL_MODE_LSB 0
`define SBA_CTRL_CLKSTOP_BIT 2
`define SBA_CTRL_HW2_BIT 3
`endif

// ==== rtl/sba_frame_timer.sv ====
// Highway-frame counter with restart on run low
`default_nettype none
module sba_frame_timer (
  input wire logic clk_i,
  input wire logic sys_rst_i,
  sba_tmr_if.tmr t
);
  import sba_pkg::*;
  sba_tmr_t r, n;
  always_comb begin
    n = r;
    if (!t.run) begin
      n.cnt = 8'h00;
      n.done = 1'b0;
    end else if (t.tick && !r.done) begin
      n.cnt = r.cnt + 8'h01;
      n.done = (r.cnt + 8'h01) == t.limit;
    end
  end
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end
  assign t.done = r.done;
endmodule : sba_frame_timer
`default_nettype wire

// ==== rtl/sba_pkg.sv ====
// Types for the S-bus layer-1 activation block
`default_nettype none
package sba_pkg;
  typedef enum logic [1:0] {
    SBA_MODE_TE = 2'h0,
    SBA_MODE_LTT = 2'h1,
    SBA_MODE_LTS = 2'h2
  } sba_mode_t;
  typedef enum logic [4:0] {
    F3_DOWN = 5'h00, F3_UP = 5'h01, F3_PEND_DEACT = 5'h02, F4_PEND_ACT = 5'h03,
    F5_UNSYNC = 5'h04, F6_SYNC = 5'h05, F7_ACTIVE = 5'h06, F8_LOST = 5'h07,
    LOOP_CLOSED = 5'h08, LOOP_ACTIVE = 5'h09, TEST_CONT = 5'h0A, TEST_SINGLE = 5'h0B,
    IDLE_RESET = 5'h0C, G1_DEACT = 5'h10, G2_WAIT = 5'h11, G2_SYNC = 5'h12,
    G3_ACTIVE = 5'h13, G4_PEND_DEACT = 5'h14
  } sba_state_t;
  typedef struct packed {
    logic [7:0] cnt;
    logic done;
  } sba_tmr_t;
  typedef struct packed {
    sba_state_t state;
    logic [3:0] ind;
    logic [2:0] tx;
    logic clk_on;
    logic [15:0] clk_cnt;
    logic prio_hi;
    logic ar_seen;
    logic slip_f;
    logic pass;
    logic loop_f;
    logic awake_en;
    logic run_a;
    logic [7:0] lim_a;
    logic run_b;
    logic [31:0] rdata;
    sba_mode_t mode;
    logic clkstop;
    logic hw2;
    logic rp1, rp2, dl1, dl2, cs1, cs2;
  } sba_core_t;
endpackage : sba_pkg
`default_nettype wire

// ==== rtl/sba_tmr_if.sv ====
// Frame timer handshake between the state machine and its timers
`default_nettype none
interface sba_tmr_if;
  logic tick;
  logic run;
  logic [7:0] limit;
  logic done;
  modport ctl (output tick, output run, output limit, input done);
  modport tmr (input tick, input run, input limit, output done);
endinterface : sba_tmr_if
`default_nettype wire

// ==== tb/sba_activation_assertions.sv ====
// Port-level checker for the S-bus activation block
`include "sba_defs.svh"
`default_nettype none
module sba_activation_assertions #(
  parameter logic [15:0] CLK_START_CYC = 16'h0008
) (
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic [3:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic wr_stb_i,
  input wire logic [3:0] cmd_i,
  input wire logic [3:0] ind_o,
  input wire logic [2:0] rx_info_i,
  input wire logic reset_pin_i,
  input wire logic [2:0] tx_info_o,
  input wire logic clocks_on_o,
  input wire logic awake_en_o,
  input wire logic loop_o
);
  logic [1:0] mode_r;
  logic cs_r;
  logic [15:0] run_r;
  logic te;
  logic lts;
  // Mode is shadowed from bus writes since the checker sees only ports
  assign te = (mode_r != 2'h1) && (mode_r != 2'h2);
  assign lts = (mode_r == 2'h2);
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      mode_r <= 2'h0;
      cs_r <= 1'b0;
      run_r <= 16'h0000;
    end else begin
      if (wr_stb_i && addr_i == `SBA_REG_CTRL) begin
        mode_r <= wdata_i[1:0];
        cs_r <= wdata_i[`SBA_CTRL_CLKSTOP_BIT];
      end
      run_r <= cs_r ? 16'h0000 : ((run_r == 16'hFFFF) ? run_r : run_r + 16'h0001);
    end
  end
  default clocking @(posedge clk_i);
  endclocking
  default disable iff (sys_rst_i);
  sequence pin_hi;
    (te && !cs_r && reset_pin_i)[*5];
  endsequence
  sequence loop_quiet;
    (te && loop_o && rx_info_i == `SBA_INFO0)[*3];
  endsequence
  sequence info2_held;
    (te && !reset_pin_i && cmd_i[3:1] == 3'h4 && rx_info_i == `SBA_INFO2)[*6];
  endsequence
  sequence info3_held;
    (lts && cmd_i == `SBA_LT_DEACT_ACK_DOWN && rx_info_i == `SBA_INFO3
      && tx_info_o == `SBA_INFO2) ##1 (rx_info_i == `SBA_INFO3)[*2];
  endsequence
  chk_soft_reset_idle: assert property (
    te && !reset_pin_i && cmd_i == `SBA_SOFT_RESET_COMMAND |-> ##[1:3]
    (ind_o == `SBA_ERROR_CODE && !awake_en_o && tx_info_o == `SBA_INFO0))
    else $error("soft reset did not reach idle");
  chk_pin_error: assert property (pin_hi |-> ind_o == `SBA_ERROR_CODE)
    else $error("reset pin without error code");
  chk_clocks_kept: assert property (run_r > CLK_START_CYC + 16'h0004 |-> clocks_on_o)
    else $error("clocks stopped with clock stop clear");
  chk_awake_up: assert property (te && ind_o == `SBA_CLOCKS_UP_INDICATION |-> awake_en_o)
    else $error("awake detector off in power up");
  chk_loop_code: assert property (loop_quiet |-> ind_o == `SBA_LOOPBACK_TEST_CODE)
    else $error("loop without test code");
  chk_flywheel_src: assert property (
    te && $changed(ind_o) && ind_o == `SBA_DEACTIVATE_REQUEST_CODE
    |-> $past(rx_info_i, 8) == `SBA_INFO0 && rx_info_i == `SBA_INFO0)
    else $error("deactivate request without quiet line");
  chk_info1_stop: assert property (
    te && tx_info_o == `SBA_INFO1 && rx_info_i != `SBA_INFO0 && rx_info_i != `SBA_INFO1
    |-> ##[1:500] tx_info_o != `SBA_INFO1)
    else $error("INFO1 kept after line signal");
  chk_info2_answer: assert property (info2_held |-> tx_info_o == `SBA_INFO3)
    else $error("INFO2 not answered with INFO3");
  chk_info3_answer: assert property (info3_held |-> ##[0:3] tx_info_o == `SBA_INFO4)
    else $error("INFO3 not answered with INFO4");
endmodule : sba_activation_assertions
bind sba_activation sba_activation_assertions #(.CLK_START_CYC(CLK_START_CYC))
  sba_activation_assertions_inst (.clk_i, .sys_rst_i, .addr_i, .wdata_i, .wr_stb_i,
  .cmd_i, .ind_o, .rx_info_i, .reset_pin_i, .tx_info_o, .clocks_on_o, .awake_en_o,
  .loop_o);
`default_nettype wire

// ==== tb/sba_activation_tb.sv ====
// Self-checking bench for the S-bus activation block
`include "sba_defs.svh"
`default_nettype none
module sba_activation_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic [3:0] addr_i = 4'h0;
  logic [31:0] wdata_i = 32'h0;
  logic wr_stb_i = 1'b0;
  logic rd_stb_i = 1'b0;
  logic frame_tick_i = 1'b0;
  logic [2:0] rx_info_i = 3'h0;
  logic reset_pin_i = 1'b0;
  logic sense_i = 1'b1;
  logic [31:0] rdata_o;
  logic [3:0] cmd_i;
  logic [3:0] ind_o;
  logic [2:0] tx_info_o;
  logic clocks_on_o, awake_en_o, pass_through_o, loop_o, line_i;
  logic rd_d = 1'b0;
  logic look = 1'b0;
  logic [3:0] tcnt = 4'h0;
  integer seed = 32'hc21a;
  int n_mismatch = 0;
  int n_compared = 0;
  int sel_q[$];
  logic [31:0] exp_q[$];
  sba_activation #(.CLK_START_CYC(16'h0008)) sba_activation_inst (.clk_i, .sys_rst_i,
    .addr_i, .wdata_i, .wr_stb_i, .rd_stb_i, .rdata_o, .cmd_i, .ind_o, .frame_tick_i,
    .rx_info_i, .slip_i(1'b0), .reset_pin_i, .upstream_data_line_i(line_i),
    .bus_connected_sense_i(sense_i), .tx_info_o, .clocks_on_o, .awake_en_o,
    .pass_through_o, .loop_o);
  sba_l2_model sba_l2_model_inst (.clk_i, .cmd_o(cmd_i), .data_line_o(line_i));
  initial begin
    forever #50 clk_i = ~clk_i;
  end
  // Ten-cycle frames keep timers short
  always @(posedge clk_i) begin
    tcnt <= (tcnt == 4'h9) ? 4'h0 : tcnt + 4'h1;
    frame_tick_i <= (tcnt == 4'h9);
    rd_d <= rd_stb_i;
  end
  function automatic logic [31:0] probe(input int s);
    case (s)
      0: probe = rdata_o;
      1: probe = {28'h0, ind_o};
      2: probe = {29'h0, tx_info_o};
      3: probe = {31'h0, clocks_on_o};
      4: probe = {31'h0, awake_en_o};
      5: probe = {31'h0, pass_through_o};
      default: probe = {31'h0, loop_o};
    endcase
  endfunction : probe
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check
  // Falling-edge compare avoids edge races
  always @(negedge clk_i) begin
    if (rd_d || look) begin
      check(probe(sel_q.pop_front()), exp_q.pop_front());
    end
  end
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk_i);
    addr_i <= a;
    wdata_i <= d;
    wr_stb_i <= 1'b1;
    @(posedge clk_i);
    wr_stb_i <= 1'b0;
  endtask : wr
  task automatic rd(input logic [3:0] a, input logic [31:0] e);
    @(posedge clk_i);
    addr_i <= a;
    rd_stb_i <= 1'b1;
    sel_q.push_back(0);
    exp_q.push_back(e);
    @(posedge clk_i);
    rd_stb_i <= 1'b0;
  endtask : rd
  task automatic see(input int s, input logic [31:0] e);
    int k;
    k = 0;
    @(negedge clk_i);
    while (probe(s) !== e && k < 3000) begin
      @(negedge clk_i);
      k++;
    end
    sel_q.push_back(s);
    exp_q.push_back(e);
    look <= 1'b1;
    @(negedge clk_i);
    look <= 1'b0;
  endtask : see
  task automatic ctl(input logic [3:0] c);
    sba_l2_model_inst.issue(c, 1'b0);
  endtask : ctl
  task automatic lin(input logic [2:0] v);
    @(posedge clk_i);
    rx_info_i <= v;
  endtask : lin
  task automatic done(input string s);
    $display("test %s finished", s);
  endtask : done
  task automatic summarize();
    $display("compared %0d mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : summarize
  initial begin
    repeat (20000) @(posedge clk_i);
    n_mismatch++;
    summarize();
  end
  initial begin
    repeat (3) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    see(1, `SBA_DEACTIVATE_ACK_DOWN);
    for (int i = 2; i < 7; i++) see(i, {31'h0, i == 3 || i == 4});
    rd(`SBA_REG_STATUS, 32'h000003C5);
    wr(`SBA_REG_STATUS, $random(seed));
    rd(`SBA_REG_CTRL, 32'h0);
    rd(4'h8, 32'h0);
    done("reset");
    ctl(`SBA_CLOCK_REQUEST_CODE);
    see(1, `SBA_CLOCKS_UP_INDICATION);
    ctl(`SBA_DEACTIVATE_UP_CODE);
    see(1, `SBA_DEACTIVATE_ACK_DOWN);
    @(posedge clk_i);
    sense_i <= 1'b0;
    ctl(`SBA_CLOCK_REQUEST_CODE);
    see(1, `SBA_UNPLUGGED_CODE);
    ctl(`SBA_DEACTIVATE_UP_CODE);
    see(1, `SBA_DEACTIVATE_ACK_DOWN);
    @(posedge clk_i);
    sense_i <= 1'b1;
    sba_l2_model_inst.pull(1'b0);
    see(1, `SBA_CLOCKS_UP_INDICATION);
    sba_l2_model_inst.pull(1'b1);
    done("power up");
    ctl(`SBA_ACTIVATE_PRIO_LOW_COMMAND);
    see(2, `SBA_INFO1);
    see(1, `SBA_CLOCKS_UP_INDICATION);
    lin(`SBA_RX_UNSYNCED);
    see(1, `SBA_LEVEL_UNSYNCED_CODE);
    lin(`SBA_INFO2);
    see(2, `SBA_INFO3);
    see(1, `SBA_ACTIVATE_REQUEST_DOWN);
    lin(`SBA_INFO4);
    see(1, `SBA_ACTIVE_PRIORITY_LOW);
    ctl(`SBA_ACTIVATE_PRIO_HIGH_COMMAND);
    see(1, `SBA_ACTIVE_PRIORITY_HIGH);
    lin(`SBA_INFO0);
    see(1, `SBA_DEACTIVATE_REQUEST_CODE);
    ctl(`SBA_ACTIVATE_PRIO_LOW_COMMAND);
    repeat (20) @(posedge clk_i);
    see(1, `SBA_DEACTIVATE_REQUEST_CODE);
    ctl(`SBA_DEACTIVATE_UP_CODE);
    see(1, `SBA_DEACTIVATE_ACK_DOWN);
    done("activation");
    wr(`SBA_REG_CTRL, 32'h00000008);
    ctl(`SBA_CLOCK_REQUEST_CODE);
    lin(`SBA_INFO2);
    see(2, `SBA_INFO3);
    lin(`SBA_INFO4);
    repeat (10) @(posedge clk_i);
    see(5, 32'h0);
    ctl(`SBA_ACTIVATE_PRIO_LOW_COMMAND);
    see(1, `SBA_ACTIVE_PRIORITY_LOW);
    see(5, 32'h1);
    lin(`SBA_INFO0);
    see(1, `SBA_DEACTIVATE_REQUEST_CODE);
    ctl(`SBA_DEACTIVATE_UP_CODE);
    see(1, `SBA_DEACTIVATE_ACK_DOWN);
    wr(`SBA_REG_CTRL, 32'h0);
    done("second highway mode");
    ctl(`SBA_LOOP_ACTIVATE_COMMAND);
    see(6, 32'h1);
    see(1, `SBA_LOOPBACK_TEST_CODE);
    lin(`SBA_RX_UNSYNCED);
    see(1, `SBA_AWAKE_LOOPBACK_CODE);
    lin(`SBA_INFO0);
    ctl(`SBA_CONTINUOUS_PULSE_COMMAND);
    see(2, `SBA_TX_CONT);
    see(1, `SBA_LOOPBACK_TEST_CODE);
    ctl(`SBA_SINGLE_PULSE_COMMAND);
    see(2, `SBA_TX_SINGLE);
    ctl(`SBA_DEACTIVATE_UP_CODE);
    see(1, `SBA_DEACTIVATE_ACK_DOWN);
    done("test modes");
    ctl(`SBA_SOFT_RESET_COMMAND);
    see(1, `SBA_ERROR_CODE);
    see(4, 32'h0);
    see(3, 32'h1);
    sba_l2_model_inst.issue(`SBA_ACTIVATE_PRIO_LOW_COMMAND, 1'b1);
    repeat (10) @(posedge clk_i);
    see(1, `SBA_ERROR_CODE);
    ctl(`SBA_DEACTIVATE_UP_CODE);
    see(1, `SBA_DEACTIVATE_ACK_DOWN);
    see(4, 32'h1);
    @(posedge clk_i);
    reset_pin_i <= 1'b1;
    see(1, `SBA_ERROR_CODE);
    see(4, 32'h0);
    @(posedge clk_i);
    reset_pin_i <= 1'b0;
    see(4, 32'h1);
    done("resets");
    wr(`SBA_REG_CTRL, 32'h00000002);
    lin(`SBA_INFO1);
    see(1, `SBA_ACTIVATE_REQUEST_UP);
    see(2, `SBA_INFO2);
    lin(`SBA_INFO3);
    see(2, `SBA_INFO4);
    see(1, `SBA_ACTIVATE_INDICATION_UP);
    lin(`SBA_RX_UNSYNCED);
    see(2, `SBA_INFO2);
    see(1, `SBA_LOST_FRAMING_UP_CODE);
    lin(`SBA_INFO3);
    see(2, `SBA_INFO4);
    ctl(`SBA_LT_DEACT_REQUEST);
    repeat (800) @(posedge clk_i);
    see(1, `SBA_ACTIVATE_INDICATION_UP);
    see(1, `SBA_LT_DEACTIVATED_CODE);
    ctl(`SBA_LT_CONT_PULSE);
    see(2, `SBA_TX_CONT);
    ctl(`SBA_LT_SINGLE_PULSE);
    see(2, `SBA_TX_SINGLE);
    ctl(`SBA_LT_LOOP_ACTIVATE);
    see(6, 32'h1);
    done("line termination");
    summarize();
  end
endmodule : sba_activation_tb
`default_nettype wire

// ==== tb/sba_l2_model.sv ====
// Controller model issuing command codes as held levels
`include "sba_defs.svh"
`default_nettype none
module sba_l2_model (
  input wire logic clk_i,
  output logic [3:0] cmd_o,
  output logic data_line_o
);
  logic idle_r;
  initial begin
    cmd_o = `SBA_DEACTIVATE_UP_CODE;
    data_line_o = 1'b1;
    idle_r = 1'b0;
  end
  // A rude issue skips the idle exit so refusal can be exercised
  task automatic issue(input logic [3:0] c, input logic rude);
    if (idle_r && !rude && c != `SBA_DEACTIVATE_UP_CODE) begin
      @(posedge clk_i);
      cmd_o <= `SBA_DEACTIVATE_UP_CODE;
      repeat (4) @(posedge clk_i);
    end
    @(posedge clk_i);
    cmd_o <= c;
    idle_r = (c == `SBA_SOFT_RESET_COMMAND) || (idle_r && c != `SBA_DEACTIVATE_UP_CODE);
  endtask : issue
  task automatic pull(input logic v);
    @(posedge clk_i);
    data_line_o <= v;
  endtask : pull
endmodule : sba_l2_model
`default_nettype wire
